// >>> src/capspace_pkg.sv
package capspace_pkg;
  // Configuration word offsets (byte addresses)
  localparam logic [7:0]  OFS_SUBSYS    = 8'h2c;
  localparam logic [7:0]  OFS_CAP_HEAD  = 8'h34;
  localparam logic [7:0]  OFS_INT_LAT   = 8'h3c;
  localparam logic [7:0]  OFS_DEV_CTL   = 8'h40;
  localparam logic [7:0]  OFS_PD_CAP    = 8'h44;
  localparam logic [7:0]  OFS_PD_WORD   = 8'h48;
  localparam logic [7:0]  OFS_PWR_CAP   = 8'h4c;
  localparam logic [7:0]  OFS_PWR_CSR   = 8'h50;
  // Fixed field values
  localparam int          LAT_UNIT_NS   = 250;
  localparam logic [6:0]  MAX_LAT_VAL   = 7'h28;
  localparam logic [8:0]  MIN_GNT_VAL   = 9'h010;
  localparam logic [7:0]  INT_PIN_VAL   = 8'h01;
  localparam logic [7:0]  CAP_HEAD_VAL  = 8'h44;
  localparam logic [7:0]  PD_CAP_ID     = 8'h03;
  localparam logic [7:0]  PD_NEXT_PTR   = 8'h4c;
  localparam logic [7:0]  PWR_CAP_ID    = 8'h01;
  localparam logic [7:0]  PWR_NEXT_PTR  = 8'h00;
  localparam logic [4:0]  PWR_WAKE_SUP  = 5'h00;
  localparam logic        PWR_ST2_SUP   = 1'b0;
  localparam logic        PWR_ST1_SUP   = 1'b0;
  localparam logic        PWR_DSI       = 1'b1;
  localparam logic        PWR_WAKE_CLK  = 1'b0;
  localparam logic [2:0]  PWR_SPEC_VER  = 3'b010;
  // Field positions and transfer size
  localparam int          CTL_COMPAT_A  = 2;
  localparam int          CTL_COMPAT_B  = 1;
  localparam int          CTL_SVID_EN   = 0;
  localparam int          PD_FLAG_BIT   = 31;
  localparam int          PD_ADDR_LSB   = 16;
  localparam int          PD_XFER_BYTES = 4;
  // Reset values and power states
  localparam logic [7:0]  INT_LINE_RST  = 8'h00;
  localparam logic [2:0]  DEV_CTL_RST   = 3'h0;
  localparam logic [15:0] SVID_RST      = 16'h0000;
  localparam logic [1:0]  PS_D0         = 2'h0;
  localparam logic [1:0]  PS_D3HOT      = 2'h3;
endpackage

// >>> src/product_data_engine.sv
module product_data_engine #(
  parameter int BYTES = capspace_pkg::PD_XFER_BYTES
) (
  // Clock and reset
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst,
  // Transfer request
  input  wire logic               i_start,
  input  wire logic               i_write,
  input  wire logic [7:0]         i_addr,
  input  wire logic [BYTES*8-1:0] i_wdata,
  output logic                    o_busy,
  output logic                    o_done,
  output logic [BYTES*8-1:0]      o_rdata,
  // EEPROM byte port
  output logic                    o_ee_req,
  output logic                    o_ee_we,
  output logic [7:0]              o_ee_addr,
  output logic [7:0]              o_ee_wbyte,
  input  wire logic               i_ee_ack,
  input  wire logic [7:0]         i_ee_rbyte
);
  localparam int IW = $clog2(BYTES);

  if (BYTES < 2 || (1 << IW) != BYTES) begin
    $error("BYTES must be a power of two of at least 2");
  end

  typedef enum logic {ST_IDLE, ST_XFER} eng_state_e;

  eng_state_e             state_q;
  logic [IW-1:0]          idx_q;
  logic [BYTES*8-1:0]     data_q;
  logic                   we_q;
  logic [7:0]             addr_q;
  logic [7:0]             wbyte_q;
  logic                   done_q;
  wire                    step    = (state_q == ST_XFER) && i_ee_ack;
  wire                    last    = (idx_q == IW'(BYTES - 1));
  wire  [IW-1:0]          idx_nx  = idx_q + IW'(1);
  wire  [IW+2:0]          sel_cur = {idx_q, 3'b000};
  wire  [IW+2:0]          sel_nx  = {idx_nx, 3'b000};

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      idx_q   <= '0;
      data_q  <= '0;
      we_q    <= 1'b0;
      addr_q  <= 8'h00;
      wbyte_q <= 8'h00;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (i_start) begin
            state_q <= ST_XFER;
            idx_q   <= '0;
            data_q  <= i_wdata;
            we_q    <= i_write;
            addr_q  <= i_addr;
            wbyte_q <= i_wdata[7:0];
          end
        end
        ST_XFER: begin
          if (step) begin
            if (!we_q) begin
              data_q[sel_cur +: 8] <= i_ee_rbyte; // R13
            end
            if (last) begin
              state_q <= ST_IDLE; // R13
              done_q  <= 1'b1;
            end else begin
              idx_q   <= idx_nx;
              addr_q  <= addr_q + 8'h01; // R13
              wbyte_q <= data_q[sel_nx +: 8];
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign o_busy     = (state_q == ST_XFER);
  assign o_ee_req   = (state_q == ST_XFER);
  assign o_ee_we    = we_q;
  assign o_ee_addr  = addr_q;
  assign o_ee_wbyte = wbyte_q;
  assign o_done     = done_q;
  assign o_rdata    = data_q;

  // Helper: acknowledged bytes of the current transfer
  logic [IW:0] acks_q;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      acks_q <= '0;
    end else if (i_start && state_q == ST_IDLE) begin
      acks_q <= '0;
    end else if (step) begin
      acks_q <= acks_q + (IW+1)'(1);
    end
  end

  a_four_byte_move: assert property ( // R13
    @(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_done) |-> acks_q == (IW+1)'(BYTES))
    else $error("transfer did not move exactly four bytes");

  a_addr_step: assert property ( // R13
    @(posedge i_ref_clk) disable iff (i_rst)
    step && !last |=> o_ee_addr == $past(o_ee_addr) + 8'h01)
    else $error("byte address did not advance by one");
endmodule

// >>> src/pci_config_capability_space.sv
// Behaviour
// R1 - Interrupt word bits 31:25 read constant 0x28 latency limit, 250 ns units.
// R2 - Bits 24:16 read constant minimum grant 0x10, 250 ns units.
// R3 - Bits 15:8 read constant 0x01: interrupt on the first pin.
// R4 - Bits 7:0 are plain read/write interrupt routing storage.
// R5 - Capability list head reads constant 0x44.
// R6 - Control bits 2 and 1 are read/write compatibility enables, reset 0.
// R7 - Control bit 0, reset 0, gates writes to subsystem vendor ID.
// R8 - Product data capability reads ID 0x03, next pointer 0x4C.
// R9 - Software starts transfer writing address plus flag: 0 read, 1 write.
// R10 - Read fetches four EEPROM bytes into data word, then sets flag.
// R11 - Write stores four data bytes to EEPROM, then clears flag.
// R12 - Address field writable; only its low 8 bits are kept.
// R13 - Exactly four bytes move; low byte at address, high at address plus three.
// R14 - Power capability reports no wake support and no wake clock need.
// R15 - Power capability reports no intermediate power state support.
// R16 - Special initialisation bit reads as 1.
// R17 - Power spec version field reads binary 010.
// R18 - Power capability ID 0x01, next pointer 0x00 ends list.
// R19 - Power state writes of D1 or D2 leave the field unchanged.
// R20 - Subsystem vendor ID holds 16 bits, reset zero.
// R21 - Reserved bits read zero and ignore writes.
// R22 - Flag holds software value during transfer; no new start until done.
module pci_config_capability_space (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // Configuration access
  input  wire logic        i_cfg_rd,
  input  wire logic        i_cfg_wr,
  input  wire logic [7:0]  i_cfg_addr,
  input  wire logic [3:0]  i_cfg_be,
  input  wire logic [31:0] i_cfg_wdata,
  output logic             o_cfg_ack,
  output logic [31:0]      o_cfg_rdata,
  // Control outputs
  output logic             o_chipset_compat_a_enable,
  output logic             o_chipset_compat_b_enable,
  output logic [15:0]      o_subsys_vendor_id,
  output logic [1:0]       o_power_state_field,
  output logic [7:0]       o_interrupt_line,
  // EEPROM byte port
  output logic             o_ee_req,
  output logic             o_ee_we,
  output logic [7:0]       o_ee_addr,
  output logic [7:0]       o_ee_wbyte,
  input  wire logic        i_ee_ack,
  input  wire logic [7:0]  i_ee_rbyte
);
  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  logic [7:0]  int_line_q;
  logic [2:0]  dev_ctl_q;
  logic [15:0] svid_q;
  logic [1:0]  pstate_q;
  logic        flag_q;
  logic [7:0]  pd_addr_q;
  logic [31:0] pd_word_q;
  logic        ack_q;
  logic [31:0] rdata_q;

  logic        eng_busy;
  logic        eng_done;
  logic [31:0] eng_rdata;

  // Address decode
  wire [7:0] word_addr = {i_cfg_addr[7:2], 2'b00};
  wire       hit_svid  = word_addr == capspace_pkg::OFS_SUBSYS;
  wire       hit_head  = word_addr == capspace_pkg::OFS_CAP_HEAD;
  wire       hit_int   = word_addr == capspace_pkg::OFS_INT_LAT;
  wire       hit_ctl   = word_addr == capspace_pkg::OFS_DEV_CTL;
  wire       hit_pcap  = word_addr == capspace_pkg::OFS_PD_CAP;
  wire       hit_pword = word_addr == capspace_pkg::OFS_PD_WORD;
  wire       hit_pwrc  = word_addr == capspace_pkg::OFS_PWR_CAP;
  wire       hit_pcsr  = word_addr == capspace_pkg::OFS_PWR_CSR;

  wire wr_int   = i_cfg_wr && hit_int && i_cfg_be[0];
  wire wr_ctl   = i_cfg_wr && hit_ctl && i_cfg_be[0];
  wire wr_svid  = i_cfg_wr && hit_svid && dev_ctl_q[capspace_pkg::CTL_SVID_EN];
  wire [31:0] svid_merged = merge_be({16'h0000, svid_q}, i_cfg_wdata, i_cfg_be);
  wire ps_legal = (i_cfg_wdata[1:0] == capspace_pkg::PS_D0) ||
                  (i_cfg_wdata[1:0] == capspace_pkg::PS_D3HOT);
  wire wr_pcsr  = i_cfg_wr && hit_pcsr && i_cfg_be[0] && ps_legal;
  // Capability and data words are frozen while a transfer runs or reports
  // completion, so a new start can never meet the flag toggle
  wire pd_locked = eng_busy || eng_done;
  wire wr_pcap  = i_cfg_wr && hit_pcap && !pd_locked; // R22
  wire wr_pword = i_cfg_wr && hit_pword && !pd_locked; // R22
  wire start    = wr_pcap && i_cfg_be[3];
  wire [7:0] start_addr = i_cfg_be[2] ? i_cfg_wdata[capspace_pkg::PD_ADDR_LSB +: 8]
                                      : pd_addr_q;

  // Read words
  wire [31:0] rd_int   = {capspace_pkg::MAX_LAT_VAL, capspace_pkg::MIN_GNT_VAL,
                          capspace_pkg::INT_PIN_VAL, int_line_q};
  wire [31:0] rd_head  = {24'h000000, capspace_pkg::CAP_HEAD_VAL};
  wire [31:0] rd_ctl   = {29'h00000000, dev_ctl_q};
  wire [31:0] rd_svid  = {16'h0000, svid_q};
  wire [31:0] rd_pcap  = {flag_q, 7'h00, pd_addr_q,
                          capspace_pkg::PD_NEXT_PTR, capspace_pkg::PD_CAP_ID};
  wire [31:0] rd_pwrc  = {capspace_pkg::PWR_WAKE_SUP, capspace_pkg::PWR_ST2_SUP,
                          capspace_pkg::PWR_ST1_SUP, 3'h0, capspace_pkg::PWR_DSI,
                          1'b0, capspace_pkg::PWR_WAKE_CLK, capspace_pkg::PWR_SPEC_VER,
                          capspace_pkg::PWR_NEXT_PTR, capspace_pkg::PWR_CAP_ID};
  wire [31:0] rd_pcsr  = {30'h00000000, pstate_q};
  wire [31:0] rd_mux   = hit_int   ? rd_int :  // R1 R2 R3
                         hit_head  ? rd_head : // R5
                         hit_ctl   ? rd_ctl :
                         hit_svid  ? rd_svid :
                         hit_pcap  ? rd_pcap : // R8
                         hit_pword ? pd_word_q :
                         hit_pwrc  ? rd_pwrc : // R14 R15 R16 R17 R18
                         hit_pcsr  ? rd_pcsr :
                         32'h00000000;         // R21

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= i_cfg_rd || i_cfg_wr;
      if (i_cfg_rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      int_line_q <= capspace_pkg::INT_LINE_RST;
      dev_ctl_q  <= capspace_pkg::DEV_CTL_RST;
      svid_q     <= capspace_pkg::SVID_RST;
      pstate_q   <= capspace_pkg::PS_D0;
    end else begin
      if (wr_int) begin
        int_line_q <= i_cfg_wdata[7:0]; // R4
      end
      if (wr_ctl) begin
        dev_ctl_q <= i_cfg_wdata[2:0]; // R6 R21
      end
      if (wr_svid) begin
        svid_q <= svid_merged[15:0]; // R7 R20
      end
      if (wr_pcsr) begin
        pstate_q <= i_cfg_wdata[1:0]; // R19
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      flag_q    <= 1'b0;
      pd_addr_q <= 8'h00;
      pd_word_q <= 32'h00000000;
    end else begin
      if (eng_done) begin
        flag_q <= !flag_q; // R10 R11
      end else if (start) begin
        flag_q <= i_cfg_wdata[capspace_pkg::PD_FLAG_BIT]; // R9 R22
      end
      if (wr_pcap && i_cfg_be[2]) begin
        pd_addr_q <= i_cfg_wdata[capspace_pkg::PD_ADDR_LSB +: 8]; // R12
      end
      if (eng_done && !flag_q) begin
        pd_word_q <= eng_rdata; // R10
      end else if (wr_pword) begin
        pd_word_q <= merge_be(pd_word_q, i_cfg_wdata, i_cfg_be);
      end
    end
  end

  product_data_engine #(
    .BYTES (capspace_pkg::PD_XFER_BYTES)
  ) u_engine (
    .i_ref_clk  (i_ref_clk),
    .i_rst      (i_rst),
    .i_start    (start),
    .i_write    (i_cfg_wdata[capspace_pkg::PD_FLAG_BIT]),
    .i_addr     (start_addr),
    .i_wdata    (pd_word_q),
    .o_busy     (eng_busy),
    .o_done     (eng_done),
    .o_rdata    (eng_rdata),
    .o_ee_req   (o_ee_req),
    .o_ee_we    (o_ee_we),
    .o_ee_addr  (o_ee_addr),
    .o_ee_wbyte (o_ee_wbyte),
    .i_ee_ack   (i_ee_ack),
    .i_ee_rbyte (i_ee_rbyte)
  );

  assign o_cfg_ack                 = ack_q;
  assign o_cfg_rdata               = rdata_q;
  assign o_chipset_compat_a_enable = dev_ctl_q[capspace_pkg::CTL_COMPAT_A];
  assign o_chipset_compat_b_enable = dev_ctl_q[capspace_pkg::CTL_COMPAT_B];
  assign o_subsys_vendor_id        = svid_q;
  assign o_power_state_field       = pstate_q;
  assign o_interrupt_line          = int_line_q;

  a_int_lat_read: assert property ( // R1
    @(posedge i_ref_clk) disable iff (i_rst)
    i_cfg_rd && hit_int |=> o_cfg_rdata[31:8] == 24'h501001 &&
                            o_cfg_rdata[7:0] == $past(int_line_q))
    else $error("interrupt and latency word read wrong");

  a_cap_head_read: assert property ( // R5
    @(posedge i_ref_clk) disable iff (i_rst)
    i_cfg_rd && hit_head |=> o_cfg_rdata == 32'h00000044)
    else $error("capability head read wrong");

  a_pd_cap_read: assert property ( // R8
    @(posedge i_ref_clk) disable iff (i_rst)
    i_cfg_rd && hit_pcap |=> o_cfg_rdata[15:0] == 16'h4c03 &&
                             o_cfg_rdata[30:24] == 7'h00)
    else $error("product data capability read wrong");

  a_pwr_cap_read: assert property ( // R14
    @(posedge i_ref_clk) disable iff (i_rst)
    i_cfg_rd && hit_pwrc |=> o_cfg_rdata == 32'h00220001)
    else $error("power capability read wrong");

  a_svid_gated: assert property ( // R7
    @(posedge i_ref_clk) disable iff (i_rst)
    i_cfg_wr && hit_svid && !dev_ctl_q[0] |=> $stable(o_subsys_vendor_id))
    else $error("vendor ID changed while writes disabled");

  a_pstate_refuse: assert property ( // R19
    @(posedge i_ref_clk) disable iff (i_rst)
    i_cfg_wr && hit_pcsr && (i_cfg_wdata[1:0] ^ {i_cfg_wdata[0], i_cfg_wdata[1]}) != 2'b00
    |=> $stable(o_power_state_field))
    else $error("power state took D1 or D2");

  a_flag_read_done: assert property ( // R10
    @(posedge i_ref_clk) disable iff (i_rst)
    eng_done && !flag_q |=> flag_q && pd_word_q == $past(eng_rdata))
    else $error("read completion did not set flag and load data");

  a_flag_write_done: assert property ( // R11
    @(posedge i_ref_clk) disable iff (i_rst)
    eng_done && flag_q |=> !flag_q)
    else $error("write completion did not clear flag");

  a_flag_hold: assert property ( // R22
    @(posedge i_ref_clk) disable iff (i_rst)
    eng_busy && !eng_done |=> $stable(flag_q))
    else $error("flag moved during transfer");

  a_addr_keep: assert property ( // R12
    @(posedge i_ref_clk) disable iff (i_rst)
    start |=> o_ee_req && o_ee_addr == $past(start_addr))
    else $error("transfer did not start at written byte address");

  a_addr_write: assert property ( // R12
    @(posedge i_ref_clk) disable iff (i_rst)
    wr_pcap && i_cfg_be[2] |=> pd_addr_q == $past(i_cfg_wdata[23:16]))
    else $error("byte address field did not take written byte");

  a_min_grant_pin: assert property ( // R2 R3
    @(posedge i_ref_clk) disable iff (i_rst)
    i_cfg_rd && hit_int |=> o_cfg_rdata[24:16] == 9'h010 &&
                            o_cfg_rdata[15:8] == 8'h01)
    else $error("minimum grant or interrupt pin read wrong");

  a_int_line_write: assert property ( // R4
    @(posedge i_ref_clk) disable iff (i_rst)
    wr_int |=> o_interrupt_line == $past(i_cfg_wdata[7:0]))
    else $error("interrupt line did not take written byte");

  a_compat_write: assert property ( // R6
    @(posedge i_ref_clk) disable iff (i_rst)
    wr_ctl |=> o_chipset_compat_a_enable == $past(i_cfg_wdata[2]) &&
               o_chipset_compat_b_enable == $past(i_cfg_wdata[1]))
    else $error("compatibility enables did not take written bits");

  a_svid_write: assert property ( // R7
    @(posedge i_ref_clk) disable iff (i_rst)
    wr_svid && i_cfg_be[1:0] == 2'b11 |=>
    o_subsys_vendor_id == $past(i_cfg_wdata[15:0]))
    else $error("vendor ID write lost while enabled");

  a_pword_read: assert property ( // R10
    @(posedge i_ref_clk) disable iff (i_rst)
    i_cfg_rd && hit_pword |=> o_cfg_rdata == $past(pd_word_q))
    else $error("data word read wrong");

  a_pwr_states: assert property ( // R15 R16
    @(posedge i_ref_clk) disable iff (i_rst)
    i_cfg_rd && hit_pwrc |=> o_cfg_rdata[26:25] == 2'b00 && o_cfg_rdata[21])
    else $error("power state support bits read wrong");

  a_pwr_version_end: assert property ( // R17 R18
    @(posedge i_ref_clk) disable iff (i_rst)
    i_cfg_rd && hit_pwrc |=> o_cfg_rdata[18:16] == 3'b010 &&
                             o_cfg_rdata[15:0] == 16'h0001)
    else $error("power version or list end read wrong");

  a_pstate_take: assert property ( // R19
    @(posedge i_ref_clk) disable iff (i_rst)
    wr_pcsr |=> o_power_state_field == $past(i_cfg_wdata[1:0]))
    else $error("power state did not take D0 or D3hot");

  a_svid_read: assert property ( // R20
    @(posedge i_ref_clk) disable iff (i_rst)
    i_cfg_rd && hit_svid |=> o_cfg_rdata == {16'h0000, $past(svid_q)})
    else $error("vendor ID word read wrong");

  a_ctl_reserved: assert property ( // R21
    @(posedge i_ref_clk) disable iff (i_rst)
    i_cfg_rd && hit_ctl |=> o_cfg_rdata[31:3] == 29'h0)
    else $error("control reserved bits not zero");

  a_pcsr_reserved: assert property ( // R21
    @(posedge i_ref_clk) disable iff (i_rst)
    i_cfg_rd && hit_pcsr |=> o_cfg_rdata[31:2] == 30'h0)
    else $error("power control reserved bits not zero");

  a_unmapped_read: assert property ( // R21
    @(posedge i_ref_clk) disable iff (i_rst)
    i_cfg_rd && !(hit_int || hit_head || hit_ctl || hit_svid ||
                  hit_pcap || hit_pword || hit_pwrc || hit_pcsr)
    |=> o_cfg_rdata == 32'h00000000)
    else $error("unmapped offset did not read zero");

  a_word_frozen: assert property ( // R22
    @(posedge i_ref_clk) disable iff (i_rst)
    i_cfg_wr && hit_pword && eng_busy |=> $stable(pd_word_q))
    else $error("data word changed during transfer");

  a_no_restart: assert property ( // R22
    @(posedge i_ref_clk) disable iff (i_rst)
    i_cfg_wr && hit_pcap && eng_done |=> !eng_busy)
    else $error("transfer started in completion cycle");
endmodule

// >>> tb/eeprom_byte_model.sv
module eeprom_byte_model (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  // Answer pacing
  input  wire logic       i_slow,
  // Byte port
  input  wire logic       i_ee_req,
  input  wire logic       i_ee_we,
  input  wire logic [7:0] i_ee_addr,
  input  wire logic [7:0] i_ee_wbyte,
  output logic            o_ee_ack,
  output logic [7:0]      o_ee_rbyte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  int         wait_cnt;

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
  end

  // One ack per byte, then a gap cycle so the next address can settle
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ee_ack   <= 1'b0;
      o_ee_rbyte <= 8'h00;
      wait_cnt   <= 0;
    end else if (o_ee_ack) begin
      o_ee_ack   <= 1'b0;
      o_ee_rbyte <= ~o_ee_rbyte;
      wait_cnt   <= 0;
    end else if (i_ee_req) begin
      if (wait_cnt >= (i_slow ? 5 : 0)) begin
        o_ee_ack   <= 1'b1;
        o_ee_rbyte <= mem[i_ee_addr];
        if (i_ee_we) begin
          mem[i_ee_addr] <= i_ee_wbyte;
        end
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end else begin
      o_ee_rbyte <= ~o_ee_rbyte;
      wait_cnt   <= 0;
    end
  end
endmodule

// >>> tb/pci_config_capability_space_bench.sv
module pci_config_capability_space_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
    logic [31:0] exp;
  } row_s;

  logic        i_ref_clk, i_rst, i_cfg_rd, i_cfg_wr, o_cfg_ack, slow;
  logic [7:0]  i_cfg_addr, int_line, ee_addr, ee_wbyte, ee_rbyte;
  logic [3:0]  i_cfg_be;
  logic [31:0] i_cfg_wdata, o_cfg_rdata, rd_q;
  logic        compat_a, compat_b, ee_req, ee_we, ee_ack;
  logic [15:0] svid;
  logic [1:0]  pstate;
  int          miscompares, total_checks;
  row_s        rows [16];

  pci_config_capability_space u_dut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cfg_rd(i_cfg_rd), .i_cfg_wr(i_cfg_wr),
    .i_cfg_addr(i_cfg_addr), .i_cfg_be(i_cfg_be), .i_cfg_wdata(i_cfg_wdata),
    .o_cfg_ack(o_cfg_ack), .o_cfg_rdata(o_cfg_rdata),
    .o_chipset_compat_a_enable(compat_a), .o_chipset_compat_b_enable(compat_b),
    .o_subsys_vendor_id(svid), .o_power_state_field(pstate), .o_interrupt_line(int_line),
    .o_ee_req(ee_req), .o_ee_we(ee_we), .o_ee_addr(ee_addr), .o_ee_wbyte(ee_wbyte),
    .i_ee_ack(ee_ack), .i_ee_rbyte(ee_rbyte));

  eeprom_byte_model u_ee (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_slow(slow), .i_ee_req(ee_req),
    .i_ee_we(ee_we), .i_ee_addr(ee_addr), .i_ee_wbyte(ee_wbyte),
    .o_ee_ack(ee_ack), .o_ee_rbyte(ee_rbyte));

  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // One config cycle: strobe for one edge, ack sampled in the following cycle
  task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] b,
                     input logic [31:0] d);
    @(negedge i_ref_clk);
    i_cfg_rd    = ~w;
    i_cfg_wr    = w;
    i_cfg_addr  = a;
    i_cfg_be    = b;
    i_cfg_wdata = d;
    @(negedge i_ref_clk);
    i_cfg_rd = 1'b0;
    i_cfg_wr = 1'b0;
    check({31'h0, o_cfg_ack}, 32'h1);
    rd_q = o_cfg_rdata;
  endtask

  task automatic wait_flag(input logic v);
    int n;
    for (n = 0; n < 100; n++) begin
      cfg(1'b0, 8'h44, 4'h0, 32'h0);
      if (rd_q[31] === v) break;
    end
    check({31'h0, rd_q[31]}, {31'h0, v});
  endtask

  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    miscompares++;
    $display("watchdog expired");
    finish_test();
  end

  initial begin
    rows = '{
      '{1'b0, 8'h34, 4'h0, 32'h0, 32'h0000_0044},
      '{1'b0, 8'h3c, 4'h0, 32'h0, 32'h5010_0100},
      '{1'b1, 8'h3c, 4'hf, 32'hffff_ffff, 32'h5010_01ff},
      '{1'b0, 8'h4c, 4'h0, 32'h0, 32'h0022_0001},
      '{1'b1, 8'h40, 4'hf, 32'hffff_ffff, 32'h0000_0007},
      '{1'b1, 8'h40, 4'hf, 32'h0000_0000, 32'h0000_0000},
      '{1'b1, 8'h2c, 4'hf, 32'hffff_ffff, 32'h0000_0000},
      '{1'b1, 8'h40, 4'hf, 32'h0000_0001, 32'h0000_0001},
      '{1'b1, 8'h2c, 4'hf, 32'hffff_1234, 32'h0000_1234},
      '{1'b1, 8'h50, 4'hf, 32'h0000_0003, 32'h0000_0003},
      '{1'b1, 8'h50, 4'hf, 32'h0000_0001, 32'h0000_0003},
      '{1'b1, 8'h50, 4'hf, 32'h0000_0002, 32'h0000_0003},
      '{1'b1, 8'h50, 4'hf, 32'h0000_0000, 32'h0000_0000},
      '{1'b0, 8'h08, 4'h0, 32'h0, 32'h0000_0000},
      '{1'b1, 8'h48, 4'hf, 32'h1122_3344, 32'h1122_3344},
      '{1'b1, 8'h44, 4'h3, 32'hffff_ffff, 32'h0000_4c03}};
    miscompares  = 0;
    total_checks = 0;
    i_rst = 1'b1;
    i_cfg_rd = 1'b0;
    i_cfg_wr = 1'b0;
    i_cfg_addr = 8'h00;
    i_cfg_be = 4'h0;
    i_cfg_wdata = 32'h0;
    slow = 1'b0;
    repeat (6) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_rst = 1'b0;
    check({3'h0, compat_a, compat_b, svid, pstate, int_line, ee_req}, 32'h0);
    $display("test reset values done");

    foreach (rows[i]) begin
      if (rows[i].wr) cfg(1'b1, rows[i].addr, rows[i].be, rows[i].wdata);
      cfg(1'b0, rows[i].addr, 4'h0, 32'h0);
      check(rd_q, rows[i].exp);
    end
    check({svid, pstate, int_line, 6'h0}, {16'h1234, 2'h0, 8'hff, 6'h0});
    $display("test register table done");

    cfg(1'b1, 8'h40, 4'h1, 32'h0000_0006);
    check({30'h0, compat_a, compat_b}, 32'h3);
    $display("test compat enables done");

    // Write transfer at the top of the address space: wraps past 0xff
    slow = 1'b1;
    cfg(1'b1, 8'h48, 4'hf, 32'ha1b2_c3d4);
    cfg(1'b1, 8'h44, 4'hc, 32'hfffe_0000);
    cfg(1'b1, 8'h48, 4'hf, 32'h0000_0000);
    cfg(1'b0, 8'h44, 4'h0, 32'h0);
    check(rd_q, 32'h80fe_4c03);
    wait_flag(1'b0);
    check({u_ee.mem[8'h01], u_ee.mem[8'h00], u_ee.mem[8'hff], u_ee.mem[8'hfe]},
          32'ha1b2_c3d4);
    cfg(1'b0, 8'h48, 4'h0, 32'h0);
    check(rd_q, 32'ha1b2_c3d4);
    $display("test eeprom write done");

    // Read transfer back from the same place, fast answers
    slow = 1'b0;
    cfg(1'b1, 8'h48, 4'hf, 32'h0000_0000);
    cfg(1'b1, 8'h44, 4'hc, 32'h7ffe_0000);
    wait_flag(1'b1);
    check(rd_q, 32'h80fe_4c03);
    cfg(1'b0, 8'h48, 4'h0, 32'h0);
    check(rd_q, 32'ha1b2_c3d4);
    // Start attempt in the completion cycle is refused
    cfg(1'b1, 8'h44, 4'hc, 32'h0010_0000);
    repeat (7) @(negedge i_ref_clk);
    cfg(1'b1, 8'h44, 4'hc, 32'h8020_0000);
    cfg(1'b0, 8'h44, 4'h0, 32'h0);
    check(rd_q, 32'h8010_4c03);
    cfg(1'b0, 8'h48, 4'h0, 32'h0);
    check(rd_q, 32'h4948_4b4a);
    $display("test eeprom read done");

    // Reset in mid-transfer and with registers set
    cfg(1'b1, 8'h40, 4'h1, 32'h0000_0007);
    cfg(1'b1, 8'h50, 4'h1, 32'h0000_0003);
    cfg(1'b1, 8'h44, 4'hc, 32'h0010_0000);
    @(negedge i_ref_clk);
    i_rst = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    i_rst = 1'b0;
    check({3'h0, compat_a, compat_b, svid, pstate, int_line, ee_req}, 32'h0);
    cfg(1'b0, 8'h40, 4'h0, 32'h0);
    check(rd_q, 32'h0000_0000);
    cfg(1'b1, 8'h2c, 4'h3, 32'h0000_beef);
    cfg(1'b0, 8'h2c, 4'h0, 32'h0);
    check(rd_q, 32'h0000_0000);
    $display("test mid-run reset done");
    finish_test();
  end
endmodule
